// ===== rtl/mfs_pkg.sv
// package of register map and field constants for the fault status bank
`default_nettype none
package mfs_pkg;
  localparam int MFS_ADDR_W = 6;
  localparam int MFS_DATA_W = 8;
  localparam logic [5:0] MFS_OFS_SUMMARY = 6'h00;
  localparam logic [5:0] MFS_OFS_DETAIL_ONE = 6'h01;
  localparam logic [5:0] MFS_OFS_DETAIL_TWO = 6'h02;
  localparam logic [7:0] MFS_RST_SUMMARY = 8'h00;
  localparam logic [7:0] MFS_RST_DETAIL_ONE = 8'h00;
  localparam logic [7:0] MFS_RST_DETAIL_TWO = 8'h00;
  // summary register fields
  localparam int MFS_SUM_STEP_DOWN = 6;
  localparam int MFS_SUM_SERIAL = 5;
  localparam int MFS_SUM_OVERCURRENT = 4;
  localparam int MFS_SUM_RESET_ABSENT = 3;
  localparam int MFS_SUM_OVERVOLTAGE = 2;
  localparam int MFS_SUM_THERMAL = 1;
  localparam int MFS_SUM_ANY = 0;
  // detail one fields
  localparam int MFS_D1_WARN = 7;
  localparam int MFS_D1_SHUTDOWN = 6;
  localparam int MFS_D1_OC_LSB = 0;
  localparam int MFS_D1_OC_W = 6;
  // detail two fields
  localparam int MFS_D2_RESERVED = 7;
  localparam int MFS_D2_OTP = 6;
  localparam int MFS_D2_SD_OC = 5;
  localparam int MFS_D2_SD_UV = 4;
  localparam int MFS_D2_CP_UV = 3;
  localparam int MFS_D2_PARITY = 2;
  localparam int MFS_D2_FRAMING = 1;
  localparam int MFS_D2_BAD_ADDR = 0;
  localparam int MFS_SYNC_STAGES = 2;
  typedef enum logic [1:0] {MFS_SEL_SUMMARY, MFS_SEL_ONE, MFS_SEL_TWO,
    MFS_SEL_NONE} mfs_sel_type;
endpackage
`default_nettype wire

// ===== rtl/mfs_sync.sv
// two flip-flop synchroniser bank for asynchronous fault inputs
`default_nettype none
module mfs_sync
  import mfs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // meta_q feeds sync_q only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== rtl/mfs_rdmux.sv
// read data selector for the three status registers
`default_nettype none
module mfs_rdmux
  import mfs_pkg::*;
(
  input wire logic [MFS_ADDR_W-1:0] addr,
  input wire logic [MFS_DATA_W-1:0] summary,
  input wire logic [MFS_DATA_W-1:0] detail_one,
  input wire logic [MFS_DATA_W-1:0] detail_two,
  output logic [MFS_DATA_W-1:0] rdata,
  output logic hit
);
  function automatic mfs_sel_type mfs_decode(input logic [5:0] a);
    case (a)
      MFS_OFS_SUMMARY: mfs_decode = MFS_SEL_SUMMARY;
      MFS_OFS_DETAIL_ONE: mfs_decode = MFS_SEL_ONE;
      MFS_OFS_DETAIL_TWO: mfs_decode = MFS_SEL_TWO;
      default: mfs_decode = MFS_SEL_NONE;
    endcase
  endfunction

  always_comb begin
    hit = 1'b1;
    case (mfs_decode(addr))
      MFS_SEL_SUMMARY: rdata = summary;
      MFS_SEL_ONE: rdata = detail_one;
      MFS_SEL_TWO: rdata = detail_two;
      default: begin
        rdata = 8'h00;
        hit = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/mfs_bank.sv
// fault and status register bank of the three-phase motor driver
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`default_nettype none
module mfs_bank
  import mfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // detector levels, asynchronous to clk
  input wire logic step_down_regulator_failure,
  input wire logic serial_link_failure,
  input wire logic supply_reset_detected,
  input wire logic supply_overvoltage_flag,
  input wire logic thermal_warning_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic [MFS_D1_OC_W-1:0] switch_overcurrent,
  input wire logic otp_error,
  input wire logic step_down_overcurrent,
  input wire logic step_down_undervoltage,
  input wire logic charge_pump_undervoltage,
  // from the frame engine, same clock
  input wire logic serial_framing_error,
  input wire logic serial_bad_address_error,
  input wire logic clear_failures_command,
  input wire logic sleep_reset_pulse,
  // register access from the frame engine, same clock
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [MFS_ADDR_W-1:0] acc_addr,
  input wire logic [MFS_DATA_W-1:0] acc_wdata,
  output logic [MFS_DATA_W-1:0] acc_rdata,
  output logic acc_rvalid,
  output logic acc_hit,
  output logic [MFS_DATA_W-1:0] summary_fault_status,
  output logic [MFS_DATA_W-1:0] driver_fault_detail_one,
  output logic [MFS_DATA_W-1:0] supply_link_fault_detail_two
);
  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;

  assign raw_in = {step_down_regulator_failure, serial_link_failure,
    supply_reset_detected, supply_overvoltage_flag, thermal_warning_flag,
    thermal_shutdown_flag, switch_overcurrent, otp_error,
    step_down_overcurrent, step_down_undervoltage,
    charge_pump_undervoltage};

  // two stages; a detector glitch shorter than a clock may be missed
  mfs_sync #(.WIDTH(NSYNC)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic s_sd_fail;
  logic s_link_fail;
  logic s_por;
  logic s_ovp;
  logic s_warn;
  logic s_shut;
  logic [MFS_D1_OC_W-1:0] s_oc;
  logic s_otp;
  logic s_sd_oc;
  logic s_sd_uv;
  logic s_cp_uv;

  assign {s_sd_fail, s_link_fail, s_por, s_ovp, s_warn, s_shut, s_oc,
    s_otp, s_sd_oc, s_sd_uv, s_cp_uv} = syn;

  // ---------------------------------------------------------------
  // status registers
  // ---------------------------------------------------------------
  logic [7:0] sum_q;
  logic [7:0] sum_d;
  logic [7:0] d1_q;
  logic [7:0] d1_d;
  logic [7:0] d2_q;
  logic [7:0] d2_d;
  logic shut_latch_q;
  logic shut_latch_d;
  logic any_fault;

  always_comb begin
    // set wins over a clear in the same cycle
    shut_latch_d = shut_latch_q;
    if (clear_failures_command || sleep_reset_pulse) begin
      shut_latch_d = 1'b0;
    end
    if (s_shut) begin
      shut_latch_d = 1'b1;
    end

    d1_d = MFS_RST_DETAIL_ONE;
    d1_d[MFS_D1_WARN] = s_warn;
    d1_d[MFS_D1_SHUTDOWN] = shut_latch_d;
    // order: A low, A high, B low, B high, C low, C high
    d1_d[MFS_D1_OC_LSB +: MFS_D1_OC_W] = s_oc;

    d2_d = MFS_RST_DETAIL_TWO;
    d2_d[MFS_D2_OTP] = s_otp;
    d2_d[MFS_D2_SD_OC] = s_sd_oc;
    d2_d[MFS_D2_SD_UV] = s_sd_uv;
    d2_d[MFS_D2_CP_UV] = s_cp_uv;
    d2_d[MFS_D2_FRAMING] = serial_framing_error;
    d2_d[MFS_D2_BAD_ADDR] = serial_bad_address_error;
    d2_d[MFS_D2_PARITY] = 1'b0;
    d2_d[MFS_D2_RESERVED] = 1'b0;

    any_fault = s_sd_fail || s_link_fail || (|s_oc) || s_por || s_ovp ||
      s_warn || shut_latch_d || (|d2_d);

    sum_d = MFS_RST_SUMMARY;
    sum_d[MFS_SUM_STEP_DOWN] = s_sd_fail;
    sum_d[MFS_SUM_SERIAL] = s_link_fail || serial_framing_error ||
      serial_bad_address_error;
    sum_d[MFS_SUM_OVERCURRENT] = |s_oc;
    sum_d[MFS_SUM_RESET_ABSENT] = ~s_por;
    sum_d[MFS_SUM_OVERVOLTAGE] = s_ovp;
    sum_d[MFS_SUM_THERMAL] = s_warn || shut_latch_d;
    sum_d[MFS_SUM_ANY] = any_fault;
  end

  // status follows detectors, serial error flags and clear pulses; bus writes never reach it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shut_latch_q <= 1'b0;
      sum_q <= MFS_RST_SUMMARY;
      d1_q <= MFS_RST_DETAIL_ONE;
      d2_q <= MFS_RST_DETAIL_TWO;
    end else begin
      shut_latch_q <= shut_latch_d;
      sum_q <= sum_d;
      d1_q <= d1_d;
      d2_q <= d2_d;
    end
  end

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  logic [7:0] mux_data;
  logic mux_hit;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic hit_q;
  logic hit_d;

  // registered answer: one cycle of latency buys clean output timing
  mfs_rdmux u_rdmux (
    .addr(acc_addr),
    .summary(sum_q),
    .detail_one(d1_q),
    .detail_two(d2_q),
    .rdata(mux_data),
    .hit(mux_hit)
  );

  // a write returns the current contents and stores nothing
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = acc_valid;
    hit_d = hit_q;
    if (acc_valid) begin
      rdata_d = mux_data;
      hit_d = mux_hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q <= hit_d;
    end
  end

  assign acc_rdata = rdata_q;
  assign acc_rvalid = rvalid_q;
  assign acc_hit = hit_q;
  assign summary_fault_status = sum_q;
  assign driver_fault_detail_one = d1_q;
  assign supply_link_fault_detail_two = d2_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_STEP_DOWN: assert property ($past(s_sd_fail) == sum_q[6])
    else $error("step-down summary bit wrong");
  AST_SERIAL: assert property (serial_bad_address_error |=> sum_q[5])
    else $error("serial summary bit missing");
  AST_OC: assert property ((|s_oc) |=> sum_q[4] && (d1_q[5:0] != 6'h00))
    else $error("overcurrent summary bit missing");
  AST_POR: assert property (s_por |=> !sum_q[3])
    else $error("supply reset bit not inverted");
  AST_OVP: assert property ($past(s_ovp) == sum_q[2])
    else $error("overvoltage bit wrong");
  AST_THERM: assert property (s_warn |=> sum_q[1] && d1_q[7])
    else $error("thermal bits missing");
  AST_ANY: assert property (sum_q[6:4] != 3'b000 |-> sum_q[0])
    else $error("any-fault bit missing");
  AST_RSV: assert property (d2_q[7] == 1'b0 && d2_q[2] == 1'b0)
    else $error("reserved or parity bit set");
  AST_LATCH: assert property (d1_q[6] && !clear_failures_command
    && !sleep_reset_pulse |=> d1_q[6])
    else $error("shutdown flag dropped without clear");
  AST_PHASE: assert property (s_oc[2] |=> d1_q[2])
    else $error("phase b low flag missing");
  AST_WRITE: assert property (acc_valid && acc_write |=>
    sum_q == $past(sum_d) && d1_q == $past(d1_d) && d2_q == $past(d2_d))
    else $error("write disturbed status");
  AST_RD: assert property (acc_valid && acc_addr == MFS_OFS_SUMMARY
    |=> acc_rvalid && acc_hit && acc_rdata == $past(sum_q))
    else $error("summary read wrong");

  // per-field checks: each flag one register stage behind its source
  AST_LINK: assert property (s_link_fail |=> sum_q[5])
    else $error("link fault summary bit missing");
  AST_FRAME: assert property (serial_framing_error |=>
    sum_q[5] && d2_q[1])
    else $error("framing error bit missing");
  AST_NO_POR: assert property (!s_por |=> sum_q[3])
    else $error("supply reset absent bit not set");
  AST_CAUSE: assert property (s_ovp || s_sd_fail |=> sum_q[0])
    else $error("any-fault bit missing for supply cause");
  AST_QUIET: assert property (!sum_q[0] |-> sum_q[7:4] == 4'h0
    && sum_q[2:1] == 2'b00 && d1_q == 8'h00 && d2_q == 8'h00)
    else $error("fault shown without any-fault bit");
  AST_SUM_RSV: assert property (sum_q[7] == 1'b0)
    else $error("summary bit 7 set");
  AST_WARN: assert property (d1_q[7] == $past(s_warn))
    else $error("thermal warning flag wrong");
  AST_SHUT_SET: assert property (s_shut |=> d1_q[6] && sum_q[1])
    else $error("shutdown flag not set");
  AST_CLEAR: assert property ((clear_failures_command ||
    sleep_reset_pulse) && !s_shut |=> !d1_q[6])
    else $error("shutdown flag not cleared");
  AST_PHASE_C: assert property (d1_q[5:4] == $past(s_oc[5:4]))
    else $error("phase c flags wrong");
  AST_PHASE_BH: assert property (d1_q[3] == $past(s_oc[3]))
    else $error("phase b high flag wrong");
  AST_PHASE_A: assert property (d1_q[1:0] == $past(s_oc[1:0]))
    else $error("phase a flags wrong");
  AST_SUPPLY: assert property (d2_q[6:3] ==
    $past({s_otp, s_sd_oc, s_sd_uv, s_cp_uv}))
    else $error("supply detail bits wrong");
  AST_BAD_ADDR: assert property (d2_q[0] ==
    $past(serial_bad_address_error))
    else $error("bad address flag wrong");

  // access port: answer one cycle on, data held until the next request
  AST_RD_ONE: assert property (acc_valid &&
    acc_addr == MFS_OFS_DETAIL_ONE |=> acc_hit && acc_rdata == $past(d1_q))
    else $error("detail one read wrong");
  AST_RD_TWO: assert property (acc_valid &&
    acc_addr == MFS_OFS_DETAIL_TWO |=> acc_hit && acc_rdata == $past(d2_q))
    else $error("detail two read wrong");
  AST_MISS: assert property (acc_valid && acc_addr > MFS_OFS_DETAIL_TWO
    |=> !acc_hit && acc_rdata == 8'h00)
    else $error("unmapped read not refused");
  AST_PULSE: assert property (!acc_valid |=> !acc_rvalid)
    else $error("answer without request");
  AST_HOLD: assert property (!acc_valid |=>
    $stable(acc_rdata) && $stable(acc_hit))
    else $error("read data changed without request");

  // main scenarios
  COV_READ_ONE: cover property (acc_valid && acc_addr == MFS_OFS_DETAIL_ONE);
  COV_SHUT_CLR: cover property (d1_q[6] ##1 clear_failures_command);
  COV_BAD: cover property (acc_valid && !mux_hit);
  COV_WRITE: cover property (acc_valid && acc_write);
  COV_ALL_OC: cover property (d1_q[5:0] == 6'h3f);
endmodule
`default_nettype wire

// ===== verif/mfs_host_model.sv
// frame engine stand-in driving the register access port
`default_nettype none
module mfs_host_model
  import mfs_pkg::*;
(
  input wire logic clk,
  output logic acc_valid,
  output logic acc_write,
  output logic [MFS_ADDR_W-1:0] acc_addr,
  output logic [MFS_DATA_W-1:0] acc_wdata,
  input wire logic [MFS_DATA_W-1:0] acc_rdata,
  input wire logic acc_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = '0;
    acc_wdata = '0;
  end
  // one access; the answer is a fixed one cycle later, bounded wait
  task automatic access(input logic w, input logic [5:0] a,
    input logic [7:0] d, output logic [7:0] rd, output logic ok);
    int n;
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge clk);
    acc_valid <= 1'b0;
    // released lines show the inverse so stale values never pass
    acc_write <= ~w;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (acc_rvalid === 1'b1) ok = 1'b1;
      else @(posedge clk);
    end
    rd = acc_rdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/mfs_bank_tb.sv
// self-checking bench for the fault status bank
`default_nettype none
module mfs_bank_tb
  import mfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] f = '0;
  logic clr = 1'b0;
  logic slp = 1'b0;
  logic acc_valid, acc_write, acc_rvalid, acc_hit;
  logic [MFS_ADDR_W-1:0] acc_addr;
  logic [MFS_DATA_W-1:0] acc_wdata, acc_rdata, sum, d1, d2;
  int bad_count = 0;
  int n_tests = 0;
  initial forever #2 clk = ~clk;
  mfs_bank uut (
    .clk, .rst_n,
    .step_down_regulator_failure(f[0]), .serial_link_failure(f[1]),
    .supply_reset_detected(f[2]), .supply_overvoltage_flag(f[3]),
    .thermal_warning_flag(f[4]), .thermal_shutdown_flag(f[5]),
    .switch_overcurrent(f[11:6]), .otp_error(f[12]),
    .step_down_overcurrent(f[13]), .step_down_undervoltage(f[14]),
    .charge_pump_undervoltage(f[15]), .serial_framing_error(f[16]),
    .serial_bad_address_error(f[17]), .clear_failures_command(clr),
    .sleep_reset_pulse(slp), .acc_valid, .acc_write, .acc_addr,
    .acc_wdata, .acc_rdata, .acc_rvalid, .acc_hit,
    .summary_fault_status(sum), .driver_fault_detail_one(d1),
    .supply_link_fault_detail_two(d2));
  mfs_host_model host (.clk, .acc_valid, .acc_write, .acc_addr,
    .acc_wdata, .acc_rdata, .acc_rvalid);
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a,
    input logic [7:0] e, m, input logic eh);
    logic [7:0] v;
    logic ok;
    host.access(w, a, 8'hff, v, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      final_report();
    end
    cmp(v & m, e);
    cmp({7'h00, acc_hit}, {7'h00, eh});
  endtask
  // inputs pass two sync flops and a register: four edges is settled
  task automatic put(input logic [17:0] v);
    @(posedge clk);
    f <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [17:0] v, input logic [7:0] es, m,
    e1, e2);
    put(v);
    cmp(sum & m, es);
    cmp(d1, e1);
    cmp(d2, e2);
    xfer(1'b0, MFS_OFS_SUMMARY, es, m, 1'b1);
    xfer(1'b0, MFS_OFS_DETAIL_ONE, e1, 8'hff, 1'b1);
    xfer(1'b0, MFS_OFS_DETAIL_TWO, e2, 8'hff, 1'b1);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    cmp(sum | d1 | d2, 8'h00);
    @(posedge clk);
    f <= '0;
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp(sum, 8'h08);
    repeat (3) @(posedge clk);
    #1;
    cmp(sum, 8'h08);
    xfer(1'b0, MFS_OFS_SUMMARY, 8'h08, 8'hff, 1'b1);
    xfer(1'b0, 6'h03, 8'h00, 8'hff, 1'b0);
    xfer(1'b0, 6'h3f, 8'h00, 8'hff, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_single();
    int i;
    chk(18'h00001, 8'h49, 8'hff, 8'h00, 8'h00);
    chk(18'h00002, 8'h29, 8'hff, 8'h00, 8'h00);
    chk(18'h00008, 8'h0d, 8'hff, 8'h00, 8'h00);
    chk(18'h00010, 8'h0b, 8'hff, 8'h80, 8'h00);
    chk(18'h00004, 8'h01, 8'hff, 8'h00, 8'h00);
    for (i = 0; i < 6; i++)
      chk(18'h40 << i, 8'h19, 8'hff, 8'h01 << i, 8'h00);
    for (i = 0; i < 4; i++)
      chk(18'h01000 << i, 8'h09, 8'hff, 8'h00, 8'h40 >> i);
    chk(18'h10000, 8'h29, 8'hff, 8'h00, 8'h02);
    chk(18'h20000, 8'h29, 8'hff, 8'h00, 8'h01);
    chk(18'h3fffb, 8'h7f, 8'hff, 8'hff, 8'h7b);
    $display("test single causes done");
  endtask
  task automatic t_latch();
    int k;
    for (k = 0; k < 2; k++) begin
      chk(18'h00020, 8'h0b, 8'hff, 8'h40, 8'h00);
      chk(18'h00000, 8'h0b, 8'hff, 8'h40, 8'h00);
      @(posedge clk);
      if (k == 0) clr <= 1'b1;
      else slp <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      slp <= 1'b0;
      chk(18'h00000, 8'h08, 8'hff, 8'h00, 8'h00);
    end
    $display("test shutdown latch done");
  endtask
  task automatic t_write();
    put(18'h00010);
    xfer(1'b1, MFS_OFS_SUMMARY, 8'h0b, 8'hff, 1'b1);
    xfer(1'b1, MFS_OFS_DETAIL_ONE, 8'h80, 8'hff, 1'b1);
    xfer(1'b1, MFS_OFS_DETAIL_TWO, 8'h00, 8'hff, 1'b1);
    xfer(1'b1, 6'h03, 8'h00, 8'hff, 1'b0);
    chk(18'h00010, 8'h0b, 8'hff, 8'h80, 8'h00);
    $display("test writes ignored done");
  endtask
  initial begin
    t_reset();
    t_single();
    t_latch();
    t_write();
    // second reset lands while a fault input is still high
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
